// ===== mcx_defs.vh
// Constants for the instruction-subset execution block
`ifndef MCX_DEFS_VH
`define MCX_DEFS_VH

// Instruction select codes
`define MCX_OP_SUB_IMM 4'h0
`define MCX_OP_SWAP_MEM 4'h1
`define MCX_OP_SWAP_WORK 4'h2
`define MCX_OP_SKIP_NULL 4'h3
`define MCX_OP_COPY_SKIP 4'h4
`define MCX_OP_BIT_SKIP 4'h5
`define MCX_OP_TBL_PAGED 4'h6
`define MCX_OP_TBL_FINAL 4'h7
`define MCX_OP_XOR_WORK 4'h8
`define MCX_OP_XOR_MEM 4'h9
`define MCX_OP_XOR_IMM 4'ha

// Data memory map, shared by instructions and the register port
`define MCX_ADDR_TPL 7'h00
`define MCX_ADDR_TPH 7'h01
`define MCX_ADDR_LATCH 7'h02
`define MCX_ADDR_WORK 7'h03
`define MCX_ADDR_FLAGS 7'h04
`define MCX_ADDR_CFG 7'h05
`define MCX_RAM_LO 7'h20
`define MCX_RAM_HI 7'h7f
`define MCX_RAM_WORDS 96

// Flag register bit positions
`define MCX_FLAG_C 0
`define MCX_FLAG_HALF 1
`define MCX_FLAG_Z 2
`define MCX_FLAG_WRAP 3

// Configuration register bit: high table pointer option
`define MCX_CFG_HIPTR 0

// Program memory shape
`define MCX_PADDR_W 11
`define MCX_PDATA_W 14
`define MCX_PAGE_W 3
`define MCX_LAST_PAGE 3'h7

// Reset values
`define MCX_RST_BYTE 8'h00
`define MCX_RST_FLAGS 4'h0
`define MCX_RST_CFG 8'h00

`endif

// ===== mcx_alu.v
// Result, flag and skip logic for the executed instruction subset
`timescale 1ns/1ps
`include "mcx_defs.vh"
module mcx_alu
(
	// Operation and operands
	input wire [3:0] op_in,
	input wire [7:0] work_in,
	input wire [7:0] mem_in,
	input wire [7:0] imm_in,
	input wire [2:0] bit_in,
	// Results
	output reg [7:0] result_out,
	output reg [3:0] flags_out,
	output reg [3:0] flag_mask_out,
	output reg work_wr_out,
	output reg mem_wr_out,
	output reg skip_out
);
	wire [8:0] diff;
	wire [4:0] diff_lo;
	wire [7:0] mem_swapped;
	wire [7:0] xor_mem;
	wire [7:0] xor_imm;
	wire wrap;

	assign diff = {1'b0, work_in} + {1'b0, ~imm_in} + 9'h001;
	assign diff_lo = {1'b0, work_in[3:0]} + {1'b0, ~imm_in[3:0]} + 5'h01;
	assign mem_swapped = {mem_in[3:0], mem_in[7:4]};
	assign xor_mem = work_in ^ mem_in;
	assign xor_imm = work_in ^ imm_in;
	// Signed wrap: operand signs differ and the result sign left the working value's
	assign wrap = (work_in[7] != imm_in[7]) && (diff[7] != work_in[7]);

	always @*
	begin
		result_out = 8'h00;
		flags_out = 4'h0;
		flag_mask_out = 4'h0;
		work_wr_out = 1'b0;
		mem_wr_out = 1'b0;
		skip_out = 1'b0;
		case (op_in)
			`MCX_OP_SUB_IMM:
			begin
				result_out = diff[7:0];
				work_wr_out = 1'b1;
				flag_mask_out = 4'hf;
				flags_out[`MCX_FLAG_C] = diff[8];
				flags_out[`MCX_FLAG_HALF] = diff_lo[4];
				flags_out[`MCX_FLAG_Z] = (diff[7:0] == 8'h00);
				flags_out[`MCX_FLAG_WRAP] = wrap;
			end
			`MCX_OP_SWAP_MEM:
			begin
				result_out = mem_swapped;
				mem_wr_out = 1'b1;
			end
			`MCX_OP_SWAP_WORK:
			begin
				result_out = mem_swapped;
				work_wr_out = 1'b1;
			end
			`MCX_OP_SKIP_NULL:
				skip_out = (mem_in == 8'h00);
			`MCX_OP_COPY_SKIP:
			begin
				result_out = mem_in;
				work_wr_out = 1'b1;
				skip_out = (mem_in == 8'h00);
			end
			`MCX_OP_BIT_SKIP:
				skip_out = ~mem_in[bit_in];
			`MCX_OP_XOR_WORK:
			begin
				result_out = xor_mem;
				work_wr_out = 1'b1;
				flag_mask_out[`MCX_FLAG_Z] = 1'b1;
				flags_out[`MCX_FLAG_Z] = (xor_mem == 8'h00);
			end
			`MCX_OP_XOR_MEM:
			begin
				result_out = xor_mem;
				mem_wr_out = 1'b1;
				flag_mask_out[`MCX_FLAG_Z] = 1'b1;
				flags_out[`MCX_FLAG_Z] = (xor_mem == 8'h00);
			end
			`MCX_OP_XOR_IMM:
			begin
				result_out = xor_imm;
				work_wr_out = 1'b1;
				flag_mask_out[`MCX_FLAG_Z] = 1'b1;
				flags_out[`MCX_FLAG_Z] = (xor_imm == 8'h00);
			end
			default:
				result_out = 8'h00;
		endcase
	end
endmodule

// ===== mcx_tbl_addr.v
// Program memory address former for table reads
`timescale 1ns/1ps
`include "mcx_defs.vh"
module mcx_tbl_addr
(
	// Pointer sources
	input wire final_page_in,
	input wire hiptr_en_in,
	input wire [7:0] ptr_low_in,
	input wire [7:0] ptr_high_in,
	input wire [`MCX_PAGE_W-1:0] cur_page_in,
	// Formed address
	output reg [`MCX_PADDR_W-1:0] addr_out
);
	always @*
	begin
		if (final_page_in)
			addr_out = {`MCX_LAST_PAGE, ptr_low_in};
		else if (hiptr_en_in)
			addr_out = {ptr_high_in[`MCX_PAGE_W-1:0], ptr_low_in};
		else
			addr_out = {cur_page_in, ptr_low_in};
	end
endmodule

// ===== mcx_core_exec.v
// Execution unit for a subset of an 8-bit core's instructions
`timescale 1ns/1ps
`include "mcx_defs.vh"
// Behaviour
// - Subtract immediate: work plus inverted immediate plus one; updates all four flags.
// - Nibble swap in place rewrites the addressed byte; flags untouched.
// - Nibble swap to work register; memory and flags untouched.
// - Skip next instruction when the addressed byte is zero; no side effects.
// - A taken skip drops the prefetched instruction and adds one dummy cycle.
// - Copy byte to work register and skip if it is zero; flags untouched.
// - Skip next instruction when the selected bit is zero; two-cycle skip.
// - Paged table read with high pointer option uses both pointers.
// - Paged table read without the option uses current page and low pointer.
// - Final-page table read uses last page and low pointer; no flag effects.
// - XOR memory into work register; only zero flag changes.
// - XOR result written back to memory; only zero flag changes.
// - XOR immediate into work register; only zero flag changes.
module mcx_core_exec
(
	// Clock and reset
	input wire CLK_IN,
	input wire RST_N_IN,
	// Instruction issue
	input wire INSTR_VALID_IN,
	input wire [3:0] INSTR_OP_IN,
	input wire [6:0] INSTR_ADDR_IN,
	input wire [7:0] INSTR_IMM_IN,
	input wire [2:0] INSTR_BIT_IN,
	input wire [`MCX_PAGE_W-1:0] CUR_PAGE_IN,
	output reg INSTR_READY_OUT,
	output reg SKIP_OUT,
	// Program memory read port
	output reg PROM_RD_OUT,
	output reg [`MCX_PADDR_W-1:0] PROM_ADDR_OUT,
	input wire [`MCX_PDATA_W-1:0] PROM_DATA_IN,
	// Register port
	input wire [6:0] REG_ADDR_IN,
	input wire [7:0] REG_WDATA_IN,
	input wire REG_WR_IN,
	input wire REG_RD_IN,
	output reg [7:0] REG_RDATA_OUT,
	// Core state
	output reg [7:0] WORK_OUT,
	output reg [3:0] FLAGS_OUT
);
	localparam ST_IDLE = 2'b00;
	localparam ST_DUMMY = 2'b01;
	localparam ST_TBL_WAIT = 2'b10;
	localparam ST_TBL_DATA = 2'b11;

	reg [7:0] ram [0:`MCX_RAM_WORDS-1];
	reg [1:0] state;
	reg [1:0] next_state;
	reg [7:0] table_pointer_low;
	reg [7:0] table_pointer_high;
	reg [7:0] table_high_byte_latch;
	reg [7:0] cfg;
	reg [6:0] tbl_dest;
	reg [7:0] operand;
	reg [7:0] bus_view;
	reg [3:0] next_flags;
	wire accept;
	wire is_table;
	wire tbl_issue;
	wire ins_issue;
	wire [7:0] alu_result;
	wire [3:0] alu_flags;
	wire [3:0] alu_mask;
	wire alu_work_wr;
	wire alu_mem_wr;
	wire alu_skip;
	wire [`MCX_PADDR_W-1:0] tbl_addr;
	wire [6:0] tbl_ram_idx;
	wire [6:0] ins_ram_idx;
	wire [6:0] reg_ram_idx;
	integer i;

	assign accept = INSTR_VALID_IN && INSTR_READY_OUT;
	assign is_table = (INSTR_OP_IN == `MCX_OP_TBL_PAGED) || (INSTR_OP_IN == `MCX_OP_TBL_FINAL);
	assign tbl_issue = accept && is_table;
	assign ins_issue = accept && !is_table;
	assign ins_ram_idx = INSTR_ADDR_IN - `MCX_RAM_LO;
	assign reg_ram_idx = REG_ADDR_IN - `MCX_RAM_LO;
	assign tbl_ram_idx = tbl_dest - `MCX_RAM_LO;

	// Operand decode of the memory map; written out in place rather than through a
	// function so that every stored location is in the process's sensitivity
	always @*
	begin
		operand = 8'h00;
		if (INSTR_ADDR_IN >= `MCX_RAM_LO)
			operand = ram[ins_ram_idx];
		else
		begin
			// Gaps between the core registers and RAM read as zero
			case (INSTR_ADDR_IN)
				`MCX_ADDR_TPL: operand = table_pointer_low;
				`MCX_ADDR_TPH: operand = table_pointer_high;
				`MCX_ADDR_LATCH: operand = table_high_byte_latch;
				`MCX_ADDR_WORK: operand = WORK_OUT;
				`MCX_ADDR_FLAGS: operand = {4'h0, FLAGS_OUT};
				`MCX_ADDR_CFG: operand = cfg;
				default: operand = 8'h00;
			endcase
		end
	end

	// Same map seen from the register port
	always @*
	begin
		bus_view = 8'h00;
		if (REG_ADDR_IN >= `MCX_RAM_LO)
			bus_view = ram[reg_ram_idx];
		else
		begin
			case (REG_ADDR_IN)
				`MCX_ADDR_TPL: bus_view = table_pointer_low;
				`MCX_ADDR_TPH: bus_view = table_pointer_high;
				`MCX_ADDR_LATCH: bus_view = table_high_byte_latch;
				`MCX_ADDR_WORK: bus_view = WORK_OUT;
				`MCX_ADDR_FLAGS: bus_view = {4'h0, FLAGS_OUT};
				`MCX_ADDR_CFG: bus_view = cfg;
				default: bus_view = 8'h00;
			endcase
		end
	end

	mcx_alu u_alu
	(
		.op_in(INSTR_OP_IN),
		.work_in(WORK_OUT),
		.mem_in(operand),
		.imm_in(INSTR_IMM_IN),
		.bit_in(INSTR_BIT_IN),
		.result_out(alu_result),
		.flags_out(alu_flags),
		.flag_mask_out(alu_mask),
		.work_wr_out(alu_work_wr),
		.mem_wr_out(alu_mem_wr),
		.skip_out(alu_skip)
	);

	mcx_tbl_addr u_tbl_addr
	(
		.final_page_in(INSTR_OP_IN == `MCX_OP_TBL_FINAL),
		.hiptr_en_in(cfg[`MCX_CFG_HIPTR]),
		.ptr_low_in(table_pointer_low),
		.ptr_high_in(table_pointer_high),
		.cur_page_in(CUR_PAGE_IN),
		.addr_out(tbl_addr)
	);

	always @*
	begin
		next_state = state;
		case (state)
			ST_IDLE:
			begin
				if (tbl_issue)
					next_state = ST_TBL_WAIT;
				else if (accept && alu_skip)
					next_state = ST_DUMMY;
			end
			ST_DUMMY: next_state = ST_IDLE;
			ST_TBL_WAIT: next_state = ST_TBL_DATA;
			ST_TBL_DATA: next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	// Sequencing: ready is low for the dummy cycle and for the whole table read
	always @(posedge CLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			state <= ST_IDLE;
			INSTR_READY_OUT <= 1'b0;
			SKIP_OUT <= 1'b0;
		end
		else
		begin
			state <= next_state;
			// Holding ready low is what throws the prefetched instruction away
			INSTR_READY_OUT <= (next_state == ST_IDLE);
			SKIP_OUT <= ins_issue && alu_skip;
		end
	end

	// Table fetch request; the address stays put until the next table read
	always @(posedge CLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			PROM_RD_OUT <= 1'b0;
			PROM_ADDR_OUT <= {`MCX_PADDR_W{1'b0}};
			tbl_dest <= 7'h00;
		end
		else
		begin
			PROM_RD_OUT <= tbl_issue;
			if (tbl_issue)
			begin
				PROM_ADDR_OUT <= tbl_addr;
				tbl_dest <= INSTR_ADDR_IN;
			end
		end
	end

	// Read data stands for the one cycle after the strobe and is zero otherwise
	always @(posedge CLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
			REG_RDATA_OUT <= `MCX_RST_BYTE;
		else if (REG_RD_IN)
			REG_RDATA_OUT <= bus_view;
		else
			REG_RDATA_OUT <= 8'h00;
	end

	// Only masked flags move; skips, swaps, copies and table reads leave them alone
	// because their mask is all zero
	always @*
	begin
		next_flags = (FLAGS_OUT & ~alu_mask) | (alu_flags & alu_mask);
	end

	// Memory map storage: port writes first, instruction writes take priority
	always @(posedge CLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			table_pointer_low <= `MCX_RST_BYTE;
			table_pointer_high <= `MCX_RST_BYTE;
			table_high_byte_latch <= `MCX_RST_BYTE;
			cfg <= `MCX_RST_CFG;
			WORK_OUT <= `MCX_RST_BYTE;
			FLAGS_OUT <= `MCX_RST_FLAGS;
			for (i = 0; i < `MCX_RAM_WORDS; i = i + 1)
				ram[i] <= `MCX_RST_BYTE;
		end
		else
		begin
			if (REG_WR_IN)
			begin
				if (REG_ADDR_IN >= `MCX_RAM_LO)
					ram[reg_ram_idx] <= REG_WDATA_IN;
				else
				begin
					case (REG_ADDR_IN)
						`MCX_ADDR_TPL: table_pointer_low <= REG_WDATA_IN;
						`MCX_ADDR_TPH: table_pointer_high <= REG_WDATA_IN;
						`MCX_ADDR_LATCH: table_high_byte_latch <= REG_WDATA_IN;
						`MCX_ADDR_WORK: WORK_OUT <= REG_WDATA_IN;
						`MCX_ADDR_FLAGS: FLAGS_OUT <= REG_WDATA_IN[3:0];
						`MCX_ADDR_CFG: cfg <= REG_WDATA_IN;
						default: cfg <= cfg;
					endcase
				end
			end
			// A same-edge instruction write overrides the port write above
			if (ins_issue)
			begin
				if (alu_mem_wr)
				begin
					if (INSTR_ADDR_IN >= `MCX_RAM_LO)
						ram[ins_ram_idx] <= alu_result;
					else
					begin
						case (INSTR_ADDR_IN)
							`MCX_ADDR_TPL: table_pointer_low <= alu_result;
							`MCX_ADDR_TPH: table_pointer_high <= alu_result;
							`MCX_ADDR_LATCH: table_high_byte_latch <= alu_result;
							`MCX_ADDR_WORK: WORK_OUT <= alu_result;
							`MCX_ADDR_CFG: cfg <= alu_result;
							default: cfg <= cfg;
						endcase
					end
				end
				if (alu_work_wr)
					WORK_OUT <= alu_result;
				FLAGS_OUT <= next_flags;
			end
			if (state == ST_TBL_DATA)
			begin
				// Latch loads here on a table read; port and instruction writes to its address also change it
				table_high_byte_latch <= {2'b00, PROM_DATA_IN[`MCX_PDATA_W-1:8]};
				if (tbl_dest >= `MCX_RAM_LO)
					ram[tbl_ram_idx] <= PROM_DATA_IN[7:0];
				else
				begin
					case (tbl_dest)
						`MCX_ADDR_TPL: table_pointer_low <= PROM_DATA_IN[7:0];
						`MCX_ADDR_TPH: table_pointer_high <= PROM_DATA_IN[7:0];
						`MCX_ADDR_WORK: WORK_OUT <= PROM_DATA_IN[7:0];
						`MCX_ADDR_CFG: cfg <= PROM_DATA_IN[7:0];
						default: cfg <= cfg;
					endcase
				end
			end
		end
	end
endmodule

// ===== mcx_core_exec_monitor.sv
// Port assertions for the instruction-subset execution unit
`timescale 1ns/1ps
module mcx_core_exec_monitor
(
	// Clock and reset
	input wire CLK_IN,
	input wire RST_N_IN,
	// Instruction side
	input wire INSTR_VALID_IN,
	input wire [3:0] INSTR_OP_IN,
	input wire [7:0] INSTR_IMM_IN,
	input wire INSTR_READY_OUT,
	input wire SKIP_OUT,
	input wire PROM_RD_OUT,
	input wire [10:0] PROM_ADDR_OUT,
	// Register port and state
	input wire REG_RD_IN,
	input wire [7:0] REG_RDATA_OUT,
	input wire [7:0] WORK_OUT,
	input wire [3:0] FLAGS_OUT
);
	wire tk;
	wire [3:0] op;
	assign tk = INSTR_VALID_IN && INSTR_READY_OUT;
	assign op = INSTR_OP_IN;
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (!RST_N_IN);
	a_sub_result: assert property (tk && op == 4'h0
		|=> WORK_OUT == $past(WORK_OUT) - $past(INSTR_IMM_IN)) else $error("sub result");
	a_sub_carry: assert property (tk && op == 4'h0
		|=> FLAGS_OUT[0] == ($past(WORK_OUT) >= $past(INSTR_IMM_IN))) else $error("sub carry");
	a_zero_flag: assert property (tk && (op == 4'h0 || op == 4'h8 || op == 4'ha)
		|=> FLAGS_OUT[2] == (WORK_OUT == 8'h00)) else $error("zero flag");
	a_xor_imm: assert property (tk && op == 4'ha
		|=> WORK_OUT == $past(WORK_OUT ^ INSTR_IMM_IN)
		&& {FLAGS_OUT[3], FLAGS_OUT[1:0]} == $past({FLAGS_OUT[3], FLAGS_OUT[1:0]}))
		else $error("xor imm");
	a_flags_kept: assert property (tk && op >= 4'h1 && op <= 4'h7
		|=> $stable(FLAGS_OUT)) else $error("flags moved");
	a_skip_dummy: assert property (SKIP_OUT |-> !INSTR_READY_OUT ##1 INSTR_READY_OUT)
		else $error("skip timing");
	a_skip_cause: assert property (SKIP_OUT |-> $past(tk && op >= 4'h3 && op <= 4'h5))
		else $error("skip cause");
	a_tbl_fetch: assert property (tk && (op == 4'h6 || op == 4'h7)
		|=> PROM_RD_OUT && !INSTR_READY_OUT ##1 !PROM_RD_OUT && !INSTR_READY_OUT
		##1 INSTR_READY_OUT) else $error("table timing");
	a_last_page: assert property (tk && op == 4'h7
		|=> PROM_ADDR_OUT[10:8] == 3'h7) else $error("last page");
	a_rdata_idle: assert property (!$past(REG_RD_IN) |-> REG_RDATA_OUT == 8'h00)
		else $error("read data idle");
	c_skip: cover property (SKIP_OUT);
	c_table: cover property (PROM_RD_OUT);
	c_read: cover property (REG_RD_IN ##1 REG_RDATA_OUT != 8'h00);
endmodule
bind mcx_core_exec mcx_core_exec_monitor u_mon (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN),
	.INSTR_VALID_IN(INSTR_VALID_IN), .INSTR_OP_IN(INSTR_OP_IN), .INSTR_IMM_IN(INSTR_IMM_IN),
	.INSTR_READY_OUT(INSTR_READY_OUT), .SKIP_OUT(SKIP_OUT), .PROM_RD_OUT(PROM_RD_OUT),
	.PROM_ADDR_OUT(PROM_ADDR_OUT), .REG_RD_IN(REG_RD_IN), .REG_RDATA_OUT(REG_RDATA_OUT),
	.WORK_OUT(WORK_OUT), .FLAGS_OUT(FLAGS_OUT));

// ===== mcx_core_exec_tb_top.sv
// Self-checking bench for the instruction-subset execution unit
`timescale 1ns/1ps
`include "mcx_defs.vh"
module mcx_core_exec_tb_top;
	reg clk = 1'b0, rst_n = 1'b0, vld = 1'b0, rwr = 1'b0, rrd = 1'b0;
	reg [3:0] iop = 4'h0;
	reg [6:0] iad = 7'h00, radr = 7'h00, ra;
	reg [7:0] iim = 8'h00, rwd = 8'h00;
	reg [2:0] ibt = 3'h0, cpg = 3'h0;
	reg [13:0] prom = 14'h0000;
	reg [7:0] mm [0:127];
	reg [31:0] sd = 32'he948;
	integer n_fail = 0, num_checks = 0, cyc = 0, i;
	wire rdy, skp, prd;
	wire [10:0] padr;
	wire [7:0] rdat, work;
	wire [3:0] flg;
	mcx_core_exec u_mcx_core_exec (.CLK_IN(clk), .RST_N_IN(rst_n), .INSTR_VALID_IN(vld),
		.INSTR_OP_IN(iop), .INSTR_ADDR_IN(iad), .INSTR_IMM_IN(iim), .INSTR_BIT_IN(ibt),
		.CUR_PAGE_IN(cpg), .INSTR_READY_OUT(rdy), .SKIP_OUT(skp), .PROM_RD_OUT(prd),
		.PROM_ADDR_OUT(padr), .PROM_DATA_IN(prom), .REG_ADDR_IN(radr), .REG_WDATA_IN(rwd),
		.REG_WR_IN(rwr), .REG_RD_IN(rrd), .REG_RDATA_OUT(rdat), .WORK_OUT(work),
		.FLAGS_OUT(flg));
	initial
	begin
		forever #4 clk = ~clk;
	end
	function [31:0] nx(input [31:0] s);
		nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function [13:0] pf(input [10:0] a);
		pf = {a[5:0], a[10:3]} ^ 14'h2a5c;
	endfunction
	function [7:0] sw(input [7:0] v);
		sw = {v[3:0], v[7:4]};
	endfunction
	// Program word follows the fetched address one cycle later
	always @(posedge clk)
		prom <= pf(padr);
	task end_sim;
	begin
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	end
	endtask
	task chk(input [10:0] s, input [10:0] e);
	begin
		num_checks = num_checks + 1;
		if (s !== e)
		begin
			n_fail = n_fail + 1;
			$display("MISMATCH %0t seen %h expected %h", $time, s, e);
		end
	end
	endtask
	task wr(input [6:0] a, input [7:0] d);
	begin
		@(posedge clk);
		rwr <= 1'b1;
		radr <= a;
		rwd <= d;
		@(posedge clk);
		rwr <= 1'b0;
		if (a < 6 || a > 31)
			mm[a] = (a == 4) ? (d & 8'h0f) : d;
	end
	endtask
	task rd(input [6:0] a);
	begin
		@(posedge clk);
		rrd <= 1'b1;
		radr <= a;
		@(posedge clk);
		rrd <= 1'b0;
		#1 chk(rdat, mm[a]);
	end
	endtask
	task run(input [3:0] op, input [6:0] a, input [7:0] imm, input [2:0] b);
		reg [8:0] s;
		reg [4:0] h;
		reg [7:0] r;
		reg [10:0] pa;
		reg [13:0] t;
		reg sk, tb;
	begin
		sk = 0;
		tb = op == 4'h6 || op == 4'h7;
		r = mm[3] ^ (op == 4'ha ? imm : mm[a]);
		pa = {mm[5][0] ? mm[1][2:0] : cpg, mm[0]};
		if (op == 4'h7)
			pa[10:8] = `MCX_LAST_PAGE;
		t = pf(pa);
		case (op)
		4'h0:
		begin
			s = {1'b0, mm[3]} + {1'b0, ~imm} + 9'h001;
			h = {1'b0, mm[3][3:0]} + {1'b0, ~imm[3:0]} + 5'h01;
			mm[4] = {4'h0, (mm[3][7] ^ imm[7]) & (s[7] ^ mm[3][7]), s[7:0] == 0, h[4], s[8]};
			mm[3] = s[7:0];
		end
		4'h1: mm[a] = sw(mm[a]);
		4'h2: mm[3] = sw(mm[a]);
		4'h3: sk = mm[a] == 0;
		4'h4:
		begin
			sk = mm[a] == 0;
			mm[3] = mm[a];
		end
		4'h5: sk = !mm[a][b];
		4'h6, 4'h7:
		begin
			mm[a] = t[7:0];
			mm[2] = {2'b00, t[13:8]};
		end
		4'h8, 4'h9, 4'ha:
		begin
			if (op == 4'h9)
				mm[a] = r;
			else
				mm[3] = r;
			mm[4][2] = r == 0;
		end
		default: ;
		endcase
		@(posedge clk);
		vld <= 1'b1;
		iop <= op;
		iad <= a;
		iim <= imm;
		ibt <= b;
		@(posedge clk);
		vld <= 1'b0;
		#1 chk(skp, sk);
		chk(rdy, !(sk || tb));
		if (tb)
		begin
			chk(prd, 1'b1);
			chk(padr, pa);
			@(posedge clk);
		end
		if (sk || tb)
		begin
			@(posedge clk);
			#1 chk(rdy, 1'b1);
		end
		chk(work, mm[3]);
		chk(flg, mm[4][3:0]);
		rd(a);
		rd(7'h02);
	end
	endtask
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			n_fail = n_fail + 1;
			end_sim;
		end
	end
	initial
	begin
		for (i = 0; i < 128; i = i + 1)
			mm[i] = 8'h00;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		for (i = 0; i < 8; i = i + 1)
			rd(i[6:0]);
		wr(7'h10, 8'hff);
		rd(7'h10);
		// Every code on the first RAM byte, zero until code 6 loads it, then a signed wrap corner
		for (i = 0; i < 16; i = i + 1)
			run(i[3:0], 7'h20, 8'h00, 3'h0);
		wr(7'h03, 8'h80);
		run(4'h0, 7'h21, 8'h01, 3'h0);
		for (i = 0; i < 300; i = i + 1)
		begin
			sd = nx(sd);
			@(posedge clk);
			cpg <= sd[2:0];
			ra = 7'h20 + sd[15:8] % 96;
			wr(ra, sd[5:4] != 0 ? sd[23:16] : 8'h00);
			wr(7'h00, sd[31:24]);
			wr(7'h01, sd[7:0]);
			wr(7'h05, {7'h00, sd[6]});
			wr(7'h03, sd[19:12]);
			wr(7'h04, {4'h0, sd[11:8]});
			run(sd[28:25] % 11, ra, sd[22:15], sd[30:28]);
		end
		end_sim;
	end
endmodule
